//--- rtl/mmd_pkg.sv
// Package: memory map constants and access carrier types for the decoder
`default_nettype none
package mmd_pkg;
  localparam int ADDR_W = 20;
  // Whole space
  localparam logic [19:0] SPACE_LO = 20'h00000;
  localparam logic [19:0] SPACE_HI = 20'hFFFFF;
  // Special function register area
  localparam logic [19:0] SFR_LO = 20'h00000;
  localparam logic [19:0] SFR_HI = 20'h002FF;
  // Shared serial window inside the register area
  localparam logic [19:0] SHARE_LO = 20'h000B8;
  localparam logic [19:0] SHARE_HI = 20'h000BF;
  // Port mode register and the position of the unit select bit
  localparam logic [19:0] PORT_MODE_ADDR = 20'h000F8;
  localparam int SEL_BIT = 7;
  localparam logic [7:0] PORT_MODE_RST = 8'h00;
  // Internal RAM base
  localparam logic [19:0] RAM_LO = 20'h00400;
  localparam logic [19:0] RAM_SIZE_DEF = 20'h00800;
  // Data flash
  localparam logic [19:0] DF_LO = 20'h02400;
  localparam logic [19:0] DF_HI = 20'h02BFF;
  // Program ROM top and default size
  localparam logic [19:0] ROM_TOP = 20'h0FFFF;
  localparam logic [19:0] ROM_SIZE_DEF = 20'h0C000;
  // Fixed vector table
  localparam logic [19:0] VEC_LO = 20'h0FFDC;
  localparam logic [19:0] VEC_HI = 20'h0FFFF;
  localparam logic [7:0] UNDEF_DATA = 8'hFF;

  typedef enum logic [2:0] {
    MMD_NONE, MMD_SFR, MMD_RAM, MMD_DFLASH, MMD_ROM, MMD_VECT
  } mmd_region_e;

  // Request from the core
  typedef struct packed {
    logic valid;
    logic write;
    logic [19:0] addr;
    logic [7:0] wdata;
  } mmd_req_s;

  // Selects toward the targets
  typedef struct packed {
    logic sfr;
    logic serial_sync;
    logic serial_twowire;
    logic ram;
    logic dflash;
    logic rom;
    logic vect;
  } mmd_sel_s;
endpackage : mmd_pkg
`default_nettype wire

//--- rtl/mmd_region.sv
// Region classifier: pure address decode of one access
`default_nettype none
module mmd_region #(
  parameter logic [19:0] RAM_SIZE = mmd_pkg::RAM_SIZE_DEF,
  parameter logic [19:0] ROM_SIZE = mmd_pkg::ROM_SIZE_DEF
) (
  input wire logic [19:0] addr,
  output mmd_pkg::mmd_region_e region,
  output logic share_hit
);
  // Inclusive range check, used for every region
  function automatic logic in_rng(input logic [19:0] a,
                                  input logic [19:0] lo,
                                  input logic [19:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction : in_rng

  wire logic [19:0] ram_hi = mmd_pkg::RAM_LO + RAM_SIZE - 20'h00001;
  wire logic [19:0] rom_lo = mmd_pkg::ROM_TOP - ROM_SIZE + 20'h00001;
  wire logic hit_sfr = in_rng(addr, mmd_pkg::SFR_LO, mmd_pkg::SFR_HI);
  wire logic hit_ram = in_rng(addr, mmd_pkg::RAM_LO, ram_hi);
  wire logic hit_df = in_rng(addr, mmd_pkg::DF_LO, mmd_pkg::DF_HI);
  wire logic hit_rom = in_rng(addr, rom_lo, mmd_pkg::ROM_TOP);
  wire logic hit_vec = in_rng(addr, mmd_pkg::VEC_LO, mmd_pkg::VEC_HI);
  assign share_hit = in_rng(addr, mmd_pkg::SHARE_LO, mmd_pkg::SHARE_HI);

  // vectors win over ROM; data flash wins over a ROM that reaches it
  assign region = hit_vec ? mmd_pkg::MMD_VECT :
                  hit_sfr ? mmd_pkg::MMD_SFR :
                  hit_ram ? mmd_pkg::MMD_RAM :
                  hit_df ? mmd_pkg::MMD_DFLASH :
                  hit_rom ? mmd_pkg::MMD_ROM : mmd_pkg::MMD_NONE;
endmodule : mmd_region
`default_nettype wire

//--- rtl/mmd_decoder.sv
// Top: memory map address decoder with serial window select
// Summary of operation
// - Whole 1-Mbyte space decoded to regions
// - Program ROM ends at 0FFFFh, grows down
// - Vector table at 0FFDCh to 0FFFFh
// - Data flash at 02400h to 02BFFh
// - RAM from 00400h growing upward
// - Register area at 00000h to 002FFh
// - B8h-BFh shared, select bit picks unit
`default_nettype none
module mmd_decoder #(
  parameter logic [19:0] RAM_SIZE = mmd_pkg::RAM_SIZE_DEF,
  parameter logic [19:0] ROM_SIZE = mmd_pkg::ROM_SIZE_DEF
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire mmd_pkg::mmd_req_s req,
  input wire logic [7:0] target_rdata,
  output mmd_pkg::mmd_sel_s sel,
  output logic target_we,
  output logic [19:0] target_addr,
  output logic [7:0] target_wdata,
  output logic [7:0] rdata,
  output logic rvalid,
  output logic [2:0] region_out,
  output logic twowire_unit_select_bit
);
  mmd_pkg::mmd_region_e region;
  logic share_hit;
  logic [7:0] port_mode_reg;
  logic [7:0] next_port_mode_reg;
  logic pending_rd;
  logic pending_mapped;

  mmd_region #(
    .RAM_SIZE(RAM_SIZE),
    .ROM_SIZE(ROM_SIZE)
  ) u_region (
    .addr(req.addr),
    .region(region),
    .share_hit(share_hit)
  );

  wire logic mapped = (region != mmd_pkg::MMD_NONE);
  wire logic is_sfr = req.valid && (region == mmd_pkg::MMD_SFR);
  wire logic pmr_wr = is_sfr && req.write &&
                      (req.addr == mmd_pkg::PORT_MODE_ADDR);

  // unit select drives which serial unit sees the window
  assign twowire_unit_select_bit = port_mode_reg[mmd_pkg::SEL_BIT];
  assign next_port_mode_reg = pmr_wr ? req.wdata : port_mode_reg;

  // Selects are combinational so the target sees them in the request cycle
  always_comb begin
    sel = '0;
    if (req.valid) begin
      case (region)
        mmd_pkg::MMD_SFR: begin
          // route shared window to exactly one unit
          sel.serial_twowire = share_hit && twowire_unit_select_bit;
          sel.serial_sync = share_hit && !twowire_unit_select_bit;
          sel.sfr = !share_hit;
        end
        mmd_pkg::MMD_RAM: sel.ram = 1'b1;
        mmd_pkg::MMD_DFLASH: sel.dflash = 1'b1;
        mmd_pkg::MMD_ROM: sel.rom = 1'b1;
        mmd_pkg::MMD_VECT: sel.vect = 1'b1;
        default: sel = '0;
      endcase
    end
  end

  // a write outside every region reaches no target
  assign target_we = req.valid && req.write && mapped;
  assign target_addr = req.addr;
  assign target_wdata = req.wdata;
  assign region_out = region;

  // Port mode register lives here since it steers the decode itself
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      port_mode_reg <= mmd_pkg::PORT_MODE_RST;
    end else begin
      port_mode_reg <= next_port_mode_reg;
    end
  end

  // Reads answer two cycles later; targets return data in the cycle after the request
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pending_rd <= 1'b0;
      pending_mapped <= 1'b0;
    end else begin
      pending_rd <= req.valid && !req.write;
      pending_mapped <= mapped;
    end
  end

  // unmapped reads return a fixed filler, standing for undefined
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rvalid <= pending_rd;
      if (pending_rd) begin
        rdata <= pending_mapped ? target_rdata : mmd_pkg::UNDEF_DATA;
      end
    end
  end

  // Edges of the sized regions, watched by the boundary checks below
  wire logic [19:0] ram_end = mmd_pkg::RAM_LO + RAM_SIZE;
  wire logic [19:0] rom_base = mmd_pkg::ROM_TOP - ROM_SIZE + 20'h00001;
  wire logic reg_sel = sel.sfr || sel.serial_sync || sel.serial_twowire;

  a_vec_priority: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    req.valid && req.addr >= mmd_pkg::VEC_LO && req.addr <= mmd_pkg::VEC_HI
    |-> sel.vect && !sel.rom)
    else $error("vector access not routed to vector table");

  a_vec_floor: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    req.valid && req.addr == mmd_pkg::VEC_LO - 20'h00001 |-> !sel.vect)
    else $error("vector table selected below its base");

  a_one_select: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    req.valid |-> $countones(sel) <= 1)
    else $error("more than one target selected");

  a_idle_quiet: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    !req.valid |-> sel == '0 && !target_we)
    else $error("target selected without a request");

  a_space_top: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    req.valid && req.addr > mmd_pkg::ROM_TOP |-> sel == '0 && !target_we)
    else $error("access above program space reached a target");

  a_sfr_range: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    req.valid && req.addr <= mmd_pkg::SFR_HI |-> reg_sel)
    else $error("register address not routed to register area");

  a_sfr_edge: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    req.valid && req.addr == mmd_pkg::SFR_HI + 20'h00001 |-> !reg_sel)
    else $error("register area selected past its top");

  a_dflash_range: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    req.valid && req.addr >= mmd_pkg::DF_LO && req.addr <= mmd_pkg::DF_HI
    |-> sel.dflash)
    else $error("data flash address misrouted");

  a_dflash_edge: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    req.valid && (req.addr == mmd_pkg::DF_LO - 20'h00001 ||
                  req.addr == mmd_pkg::DF_HI + 20'h00001)
    |-> !sel.dflash)
    else $error("data flash selected outside its range");

  a_ram_base: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    req.valid && req.addr == mmd_pkg::RAM_LO |-> sel.ram)
    else $error("RAM base not selected");

  a_ram_top: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    req.valid && req.addr == ram_end - 20'h00001 |-> sel.ram)
    else $error("RAM top byte not selected");

  a_ram_past: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    req.valid && (req.addr == ram_end ||
                  req.addr == mmd_pkg::RAM_LO - 20'h00001)
    |-> !sel.ram)
    else $error("RAM selected outside its size");

  a_rom_top: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    req.valid && req.addr == mmd_pkg::VEC_LO - 20'h00001 |-> sel.rom)
    else $error("ROM below vector table not selected");

  // ROM lowest byte
  // A ROM large enough to reach data flash loses its base to it
  a_rom_base: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    req.valid && req.addr == rom_base && rom_base > mmd_pkg::DF_HI
    |-> sel.rom)
    else $error("ROM base not selected");

  a_rom_floor: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    req.valid && req.addr == rom_base - 20'h00001 |-> !sel.rom)
    else $error("ROM selected below its base");

  a_window_select: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    req.valid && req.addr >= mmd_pkg::SHARE_LO &&
    req.addr <= mmd_pkg::SHARE_HI
    |-> sel.serial_twowire == port_mode_reg[mmd_pkg::SEL_BIT] &&
        sel.serial_sync != port_mode_reg[mmd_pkg::SEL_BIT])
    else $error("shared window routed to wrong unit");

  a_window_edge: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    req.valid && (req.addr == mmd_pkg::SHARE_LO - 20'h00001 ||
                  req.addr == mmd_pkg::SHARE_HI + 20'h00001)
    |-> !sel.serial_sync && !sel.serial_twowire)
    else $error("serial unit selected outside shared window");

  a_pmr_forward: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    pmr_wr |-> sel.sfr && target_we)
    else $error("port mode write not forwarded to register area");

  a_pmr_update: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    pmr_wr |=> twowire_unit_select_bit == $past(req.wdata[mmd_pkg::SEL_BIT]))
    else $error("select bit did not follow port mode write");

  a_pmr_hold: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    !pmr_wr |=> $stable(port_mode_reg))
    else $error("port mode register changed without its write");

  a_unmapped_read: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    req.valid && !req.write && !mapped
    |-> !target_we ##2 rvalid && rdata == mmd_pkg::UNDEF_DATA)
    else $error("unmapped read not answered with filler");

  a_unmapped_write: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    req.valid && req.write && !mapped |-> !target_we && sel == '0)
    else $error("unmapped write reached a target");

  a_mapped_read: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    req.valid && !req.write && mapped
    |-> ##2 rvalid && rdata == $past(target_rdata))
    else $error("mapped read not answered with target data");

  a_no_stray: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    !(req.valid && !req.write) |-> ##2 !rvalid)
    else $error("read answer without a read request");
endmodule : mmd_decoder
`default_nettype wire

//--- testbench/mmd_target_model.sv
// Target model: memories and registers answering behind the decoder
`default_nettype none
module mmd_target_model (
  input wire logic ref_clk,
  input wire mmd_pkg::mmd_sel_s sel,
  input wire logic [19:0] target_addr,
  output logic [7:0] target_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial target_rdata = 8'h00;
  // Answer a cycle on; an idle bus toggles so stale data never matches
  always @(posedge ref_clk) begin
    if (|sel) target_rdata <= target_addr[7:0] ^ 8'h5A;
    else target_rdata <= ~target_rdata;
  end
endmodule : mmd_target_model
`default_nettype wire

//--- testbench/memory_map_address_decoder_tb_top.sv
// Testbench: core accesses against the decoder, checked per region
`default_nettype none
module memory_map_address_decoder_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(g, e, m) begin num_checks++; if ((g) !== (e)) begin \
    fails++; $display("[FAIL] %0t %s", $time, m); end end
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  mmd_pkg::mmd_req_s req = '0;
  mmd_pkg::mmd_sel_s sel;
  logic [7:0] target_rdata, target_wdata, rdata;
  logic [19:0] target_addr;
  logic target_we, rvalid, tw_bit;
  logic [2:0] region_out;
  int fails = 0;
  int num_checks = 0;
  logic share_tw = 1'b0; // Expected unit select
  // Reserved register places are kept out of this table
  localparam logic [19:0] ADDRS [18] = '{20'h000A0, 20'h0014F, 20'h00300,
    20'h003FF, 20'h00400, 20'h00BFF, 20'h00C00, 20'h023FF, 20'h02400,
    20'h02BFF, 20'h02C00, 20'h03FFF, 20'h04000, 20'h0FFDB, 20'h0FFDC,
    20'h0FFFF, 20'h10000, 20'hFFFFF};

  initial forever #2.5 ref_clk = ~ref_clk;

  mmd_decoder #(.RAM_SIZE(20'h00800), .ROM_SIZE(20'h0C000)) i_dut (
    .ref_clk(ref_clk), .nrst(nrst), .req(req), .target_rdata(target_rdata),
    .sel(sel), .target_we(target_we), .target_addr(target_addr),
    .target_wdata(target_wdata), .rdata(rdata), .rvalid(rvalid),
    .region_out(region_out), .twowire_unit_select_bit(tw_bit));
  mmd_target_model i_model (.ref_clk(ref_clk), .sel(sel),
    .target_addr(target_addr), .target_rdata(target_rdata));

  // Region code worked out from the map, priority vectors first
  function automatic logic [2:0] exp_region(input logic [19:0] a);
    if (a >= mmd_pkg::VEC_LO && a <= mmd_pkg::VEC_HI) return 3'h5;
    if (a <= mmd_pkg::SFR_HI) return 3'h1;
    if (a >= 20'h00400 && a < 20'h00C00) return 3'h2;
    if (a >= mmd_pkg::DF_LO && a <= mmd_pkg::DF_HI) return 3'h3;
    if (a >= 20'h04000 && a <= mmd_pkg::ROM_TOP) return 3'h4;
    return 3'h0;
  endfunction : exp_region

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  // One access: selects in the request cycle, read answer bounded
  task automatic acc(input logic w, input logic [19:0] a,
                     input logic [7:0] d);
    logic [2:0] r;
    logic sh;
    logic [3:0] es;
    logic [1:0] eu;
    int n;
    r = exp_region(a);
    sh = r == 3'h1 && a >= mmd_pkg::SHARE_LO && a <= mmd_pkg::SHARE_HI;
    es = {r == 3'h2, r == 3'h3, r == 3'h4, r == 3'h5};
    eu = {sh & !share_tw, sh & share_tw};
    @(posedge ref_clk);
    req <= '{valid: 1'b1, write: w, addr: a, wdata: d};
    #1;
    `CHK(region_out, r, "region")
    `CHK({sel.ram, sel.dflash, sel.rom, sel.vect}, es, "sel")
    `CHK({sel.serial_sync, sel.serial_twowire}, eu, "unit")
    if (!sh) `CHK(sel.sfr, r == 3'h1, "sfr")
    `CHK(target_we, w & (r != 3'h0), "strobe")
    `CHK({target_addr, target_wdata}, {a, d}, "pass")
    @(posedge ref_clk);
    req <= '0;
    if (!w) begin
      n = 0;
      do begin
        @(posedge ref_clk);
        #1;
        n++;
      end while (rvalid !== 1'b1 && n < 4);
      if (rvalid !== 1'b1) begin
        fails++;
        give_verdict();
      end
      `CHK(rdata, (r == 3'h0) ? 8'hFF : a[7:0] ^ 8'h5A, "rdata")
    end
    // Answer is a one-cycle pulse, and a write never raises it
    @(posedge ref_clk);
    #1;
    `CHK(rvalid, 1'b0, "no answer")
  endtask : acc

  task automatic t_reset();
    #1;
    `CHK({tw_bit, rvalid, rdata}, 10'h000, "reset")
    $display("test reset done");
  endtask : t_reset

  task automatic t_map();
    foreach (ADDRS[i]) begin
      acc(1'b0, ADDRS[i], 8'h00);
      acc(1'b1, ADDRS[i], 8'h3C);
    end
    $display("test map done");
  endtask : t_map

  // Unit select flips the shared window; unmapped writes change nothing
  task automatic t_share();
    acc(1'b1, mmd_pkg::PORT_MODE_ADDR, 8'h80);
    share_tw = 1'b1;
    acc(1'b0, 20'h000B8, 8'h00);
    acc(1'b0, 20'h000BF, 8'h00);
    acc(1'b1, 20'h100F8, 8'h00);
    #1;
    `CHK(tw_bit, 1'b1, "kept")
    acc(1'b1, mmd_pkg::PORT_MODE_ADDR, 8'h7F);
    share_tw = 1'b0;
    acc(1'b0, 20'h000BC, 8'h00);
    acc(1'b0, 20'h000B7, 8'h00);
    $display("test share done");
  endtask : t_share

  // Reset in mid-run puts the window back on the synchronous unit
  task automatic t_rst_mid();
    acc(1'b1, mmd_pkg::PORT_MODE_ADDR, 8'h80);
    `CHK(tw_bit, 1'b1, "set")
    @(posedge ref_clk);
    nrst <= 1'b0;
    #1;
    `CHK(tw_bit, 1'b0, "cleared")
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    share_tw = 1'b0;
    t_reset();
    acc(1'b0, 20'h000B8, 8'h00);
    $display("test mid reset done");
  endtask : t_rst_mid

  initial begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset();
    t_map();
    t_share();
    t_rst_mid();
    give_verdict();
  end
endmodule : memory_map_address_decoder_tb_top
`default_nettype wire
